// File: design/watchdog_timer_core.sv
`timescale 1ns/10ps
// Functional notes
// R1: Time-out in interrupt mode sets flag bit 7
// R2: Vector entry or writing one clears flag
// R3: Request needs flag, enable and global enable
// R4: Interrupt-only mode: interrupt, never reset
// R5: Combined mode: first time-out flags; vector clears both
// R6: Combined mode: unserviced second time-out resets system
// R7: Software re-arms interrupt enable outside the handler
// R8: Mode from fuse, reset enable, interrupt enable
// R9: Clearing reset enable or period needs window
// R10: Change window closes four clocks after opening
// R11: Reset-cause flag forces reset enable set
// R12: Watchdog stays enabled across its own reset
// R13: Boot software clears cause flag and enable
// R14: Period field: bit 5 high, bits 2..0 low
// R15: Codes 0..9 give 2048 doubling to 1048576 ticks
// R16: Software restarts counter before changing period
// R17: Control bits reset to zero, enable derived
// R18: Counter counts separate oscillator ticks
// R19: Software writes new values inside the window
// R20: Fuse locks reset enable on, interrupt off
// R21: Watchdog reset sets reset-cause flag
// R22: Reserved period codes act as longest period
// R23: Restart request or mode/period change clears counter
`include "watchdog_regs.svh"

module watchdog_timer_core
    import watchdog_pkg::*;
#(
    parameter int BASE_TIMEOUT = 2048,
    parameter int CNT_W        = 21
) (
    // Clock and reset
    input  wire logic        pclk,
    input  wire logic        presetn,
    // APB slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    // Processor side
    input  wire logic        global_irq_enable,
    input  wire logic        irq_vector_enter,
    input  wire logic        restart_req,
    // Pins
    input  wire logic        osc_clk_in,
    input  wire logic        always_on_fuse,
    // Outputs
    output logic             timeout_irq_req,
    output logic             system_reset_pulse
);

    ////////////////////////////////////////////////////////////////////
    // Parameter check
    generate
        if (BASE_TIMEOUT < 1 || CNT_W > 30 ||
            (longint'(BASE_TIMEOUT) << 9) > (longint'(1) << CNT_W)) begin : g_chk
            $error("watchdog_timer_core: bad BASE_TIMEOUT or CNT_W");
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////
    // State
    logic [2:0]       osc_sync_reg;
    logic             osc_level_reg;
    logic [2:0]       fuse_sync_reg;
    logic             fuse_level_reg;
    logic             irq_flag_reg;
    logic             irq_en_reg;
    logic             rst_en_reg;
    logic [3:0]       sel_reg;
    logic [3:0]       sel_last_reg;
    logic [2:0]       window_cnt_reg;
    logic             cause_reg;
    logic [CNT_W-1:0] count_reg;
    mode_type         mode_last_reg;
    logic             pready_reg;
    logic             pslverr_reg;
    logic [31:0]      prdata_reg;
    logic             irq_req_reg;
    logic             sys_rst_reg;

    ////////////////////////////////////////////////////////////////////
    // Pin synchronisers, change accepted when stages two and three agree
    wire osc_agree  = osc_sync_reg[1] == osc_sync_reg[2];
    wire osc_tick   = osc_agree & osc_sync_reg[2] & ~osc_level_reg; // [R18]
    wire fuse_agree = fuse_sync_reg[1] == fuse_sync_reg[2];

    ////////////////////////////////////////////////////////////////////
    // Bus decode
    wire acc_phase = psel & penable;
    wire commit    = acc_phase & pready_reg;
    wire ctrl_hit  = paddr == `WDT_CTRL_OFFSET;
    wire cause_hit = paddr == `WDT_CAUSE_OFFSET;
    wire bad_addr  = ~ctrl_hit & ~cause_hit;
    wire ctrl_wr   = commit & pwrite & ctrl_hit;
    wire cause_wr  = commit & pwrite & cause_hit;

    // Written fields
    wire       w_flag   = pwdata[`WDT_IRQ_FLAG_BIT];
    wire       w_ie     = pwdata[`WDT_IRQ_EN_BIT];
    wire       w_window = pwdata[`WDT_WINDOW_BIT];
    wire       w_rst_en = pwdata[`WDT_RST_EN_BIT];
    wire [3:0] w_sel    = {pwdata[`WDT_SEL_HI_BIT],
                           pwdata[`WDT_SEL_LO_MSB:`WDT_SEL_LO_LSB]}; // [R14]

    ////////////////////////////////////////////////////////////////////
    // Mode decode
    wire window_open = window_cnt_reg != `WDT_WINDOW_CLOSED;
    wire rst_en_eff  = rst_en_reg | cause_reg | fuse_level_reg; // [R11] [R20]
    wire ie_eff      = irq_en_reg & ~fuse_level_reg;            // [R20]
    wire mode_type mode = fuse_level_reg ? mode_reset
                        : mode_type'({rst_en_eff, ie_eff});     // [R8]

    // Period select, reserved codes clamp to longest
    wire [3:0] sel_eff = (sel_reg > `WDT_SEL_MAX) ? `WDT_SEL_MAX
                                                  : sel_reg;   // [R22]
    wire [CNT_W-1:0] limit = CNT_W'(BASE_TIMEOUT) << sel_eff;  // [R15]

    wire running  = mode != mode_stopped;
    wire timeout  = running & osc_tick & (count_reg == limit - 1'b1);
    wire flag_set = timeout & ((mode == mode_irq) |
                    ((mode == mode_irq_reset) & ~irq_flag_reg)); // [R1] [R4] [R5]
    wire rst_fire = timeout & ((mode == mode_reset) |
                    ((mode == mode_irq_reset) & irq_flag_reg));  // [R6]
    wire flag_clr = irq_vector_enter | (ctrl_wr & w_flag);       // [R2]
    wire restart  = restart_req | timeout | (mode != mode_last_reg) |
                    (sel_reg != sel_last_reg);                   // [R23]

    // Guarded writes
    wire rst_en_take = ctrl_wr & (w_rst_en | window_open);       // [R9]
    wire sel_take    = ctrl_wr & window_open;                    // [R9]
    wire win_start   = ctrl_wr & w_window & w_rst_en;
    wire win_close   = ctrl_wr & ~w_window & window_open;

    ////////////////////////////////////////////////////////////////////
    // Next values
    wire irq_flag_next = flag_set | (irq_flag_reg & ~flag_clr & ~rst_fire);
    wire irq_en_next   = rst_fire ? 1'b0
                       : (irq_vector_enter & rst_en_eff) ? 1'b0    // [R5]
                       : ctrl_wr ? w_ie : irq_en_reg;
    wire rst_en_next   = rst_en_take ? w_rst_en : rst_en_reg;     // [R12]
    wire [3:0] sel_next = rst_fire ? `WDT_SEL_RESET
                        : sel_take ? w_sel : sel_reg;
    wire [2:0] window_next =
        (rst_fire | win_close) ? `WDT_WINDOW_CLOSED
        : win_start ? `WDT_WINDOW_CYCLES
        : window_open ? window_cnt_reg - 3'h1 : window_cnt_reg;   // [R10]
    wire cause_next = rst_fire |
                      (cause_reg & ~(cause_wr & ~pwdata[`WDT_CAUSE_BIT])); // [R21]
    wire [CNT_W-1:0] count_next =
        (restart | ~running) ? '0
        : osc_tick ? count_reg + 1'b1 : count_reg;
    wire irq_req_next = irq_flag_reg & ie_eff & global_irq_enable; // [R3]

    // Read data
    wire [31:0] ctrl_rd = {24'h0, irq_flag_reg, ie_eff, sel_reg[3],
                           window_open, rst_en_eff, sel_reg[2:0]}; // [R14]
    wire [31:0] cause_rd = 32'(cause_reg) << `WDT_CAUSE_BIT;
    wire [31:0] rd_mux = ctrl_hit ? ctrl_rd
                       : cause_hit ? cause_rd : `WDT_DATA_ZERO;
    wire        rd_take = acc_phase & ~pready_reg & ~pwrite;

    ////////////////////////////////////////////////////////////////////
    // Synchronisers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            osc_sync_reg   <= 3'h0;
            osc_level_reg  <= 1'b0;
            fuse_sync_reg  <= 3'h0;
            fuse_level_reg <= 1'b0;
        end else begin
            osc_sync_reg  <= {osc_sync_reg[1:0], osc_clk_in};
            fuse_sync_reg <= {fuse_sync_reg[1:0], always_on_fuse};
            if (osc_agree) begin
                osc_level_reg <= osc_sync_reg[2];
            end
            if (fuse_agree) begin
                fuse_level_reg <= fuse_sync_reg[2];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Control state
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin // [R17]
            irq_flag_reg   <= 1'b0;
            irq_en_reg     <= 1'b0;
            rst_en_reg     <= 1'b0;
            sel_reg        <= `WDT_SEL_RESET;
            sel_last_reg   <= `WDT_SEL_RESET;
            window_cnt_reg <= `WDT_WINDOW_CLOSED;
            cause_reg      <= 1'b0;
            mode_last_reg  <= mode_stopped;
        end else begin
            irq_flag_reg   <= irq_flag_next;
            irq_en_reg     <= irq_en_next;
            rst_en_reg     <= rst_en_next;
            sel_reg        <= sel_next;
            sel_last_reg   <= sel_reg;
            window_cnt_reg <= window_next;
            cause_reg      <= cause_next;
            mode_last_reg  <= mode;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Counter and outputs
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            count_reg   <= '0;
            irq_req_reg <= 1'b0;
            sys_rst_reg <= 1'b0;
        end else begin
            count_reg   <= count_next;
            irq_req_reg <= irq_req_next;
            sys_rst_reg <= rst_fire;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // APB answer, one wait cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready_reg  <= 1'b0;
            pslverr_reg <= 1'b0;
            prdata_reg  <= `WDT_DATA_ZERO;
        end else begin
            pready_reg  <= acc_phase & ~pready_reg;
            pslverr_reg <= acc_phase & ~pready_reg & bad_addr;
            if (rd_take) begin
                prdata_reg <= rd_mux;
            end
        end
    end

    assign prdata             = prdata_reg;
    assign pready             = pready_reg;
    assign pslverr            = pslverr_reg;
    assign timeout_irq_req    = irq_req_reg;
    assign system_reset_pulse = sys_rst_reg;

    ////////////////////////////////////////////////////////////////////
    // Assertions
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    irq_flag_set_a: assert property (
        timeout && mode == mode_irq |=> irq_flag_reg) // [R1]
        else $error("flag not set on interrupt time-out");

    flag_clear_a: assert property (
        irq_vector_enter && !flag_set |=> !irq_flag_reg) // [R2]
        else $error("flag not cleared on vector entry");

    irq_request_a: assert property (
        timeout_irq_req |-> $past(irq_flag_reg) && $past(ie_eff)
            && $past(global_irq_enable)) // [R3]
        else $error("interrupt request without flag and enable");

    irq_only_a: assert property (
        timeout && mode == mode_irq |=> !system_reset_pulse) // [R4]
        else $error("reset issued in interrupt-only mode");

    combined_first_a: assert property (
        timeout && mode == mode_irq_reset && !irq_flag_reg
        |=> irq_flag_reg && !system_reset_pulse) // [R5]
        else $error("first combined time-out misbehaved");

    combined_reset_a: assert property (
        timeout && mode == mode_irq_reset && irq_flag_reg
        |=> system_reset_pulse ##1 !system_reset_pulse) // [R6]
        else $error("unserviced time-out gave no reset pulse");

    fuse_lock_a: assert property (
        fuse_level_reg |-> mode == mode_reset && !ie_eff) // [R8] [R20]
        else $error("fuse did not force reset mode");

    window_guard_a: assert property (
        ctrl_wr && !window_open && !w_rst_en && !rst_fire
        |=> rst_en_reg == $past(rst_en_reg)
            && sel_reg == $past(sel_reg)) // [R9]
        else $error("guarded field changed outside window");

    window_close_a: assert property (
        win_start ##1 (!ctrl_wr && !rst_fire)[*4]
        |-> window_open ##1 !window_open) // [R10]
        else $error("change window length is not four cycles");

    reset_cause_a: assert property (
        system_reset_pulse |-> cause_reg && rst_en_eff) // [R11] [R21]
        else $error("watchdog reset without cause flag");

    period_limit_a: assert property (
        timeout |-> sel_eff <= `WDT_SEL_MAX) // [R22]
        else $error("period select beyond longest code");

    restart_a: assert property (
        restart_req |=> count_reg == '0) // [R23]
        else $error("counter not cleared by restart");

endmodule // watchdog_timer_core

// File: shared/watchdog_regs.svh
`ifndef WATCHDOG_REGS_SVH
`define WATCHDOG_REGS_SVH

// Register byte addresses
`define WDT_CTRL_OFFSET   12'h000
`define WDT_CAUSE_OFFSET  12'h004

// Control and status field positions
`define WDT_IRQ_FLAG_BIT  7
`define WDT_IRQ_EN_BIT    6
`define WDT_SEL_HI_BIT    5
`define WDT_WINDOW_BIT    4
`define WDT_RST_EN_BIT    3
`define WDT_SEL_LO_MSB    2
`define WDT_SEL_LO_LSB    0
`define WDT_CAUSE_BIT     3

// Reset values and limits
`define WDT_SEL_RESET     4'h0
`define WDT_SEL_MAX       4'h9
`define WDT_WINDOW_CYCLES 3'h4
`define WDT_WINDOW_CLOSED 3'h0
`define WDT_DATA_ZERO     32'h0000_0000

`endif

// File: shared/watchdog_pkg.sv
package watchdog_pkg;

    typedef enum logic [1:0] {
        mode_stopped   = 2'b00,
        mode_irq       = 2'b01,
        mode_reset     = 2'b10,
        mode_irq_reset = 2'b11
    } mode_type;

endpackage

// File: test/watchdog_timer_core_tb.sv
`timescale 1ns/10ps
module watchdog_timer_core_tb;
    logic        pclk = 1'b0;
    logic        presetn = 1'b0;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0000_0000;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        global_irq_enable = 1'b0;
    logic        irq_vector_enter = 1'b0;
    logic        restart_req = 1'b1;
    logic        osc_clk_in = 1'b0;
    logic        always_on_fuse = 1'b0;
    logic        timeout_irq_req;
    logic        system_reset_pulse;
    logic [33:0] notes[$];
    logic [33:0] note;
    int          n_fail = 0;
    int          checks_done = 0;
    int          n_rst = 0;
    int          cycles = 0;

    watchdog_timer_core #(.BASE_TIMEOUT(2), .CNT_W(21)) watchdog_timer_core_inst (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr),
        .global_irq_enable(global_irq_enable),
        .irq_vector_enter(irq_vector_enter), .restart_req(restart_req),
        .osc_clk_in(osc_clk_in), .always_on_fuse(always_on_fuse),
        .timeout_irq_req(timeout_irq_req),
        .system_reset_pulse(system_reset_pulse));

////////////////////////////////////////////////////////////////////////////
    always #12.5 pclk = ~pclk;

    // Slow oscillator, eight clocks a period
    always begin
        repeat (4) @(posedge pclk);
        osc_clk_in <= ~osc_clk_in;
    end

    always @(posedge pclk) begin
        cycles++;
        if (system_reset_pulse === 1'b1) n_rst++;
        if (cycles == 20000) begin
            n_fail++;
            report_and_stop;
        end
    end

    // Bus result watcher
    always @(posedge pclk) begin
        if (psel && penable && pready === 1'b1) begin
            note = notes.pop_front();
            check(pslverr, note[32]);
            if (note[33]) check(prdata, note[31:0]);
        end
    end

////////////////////////////////////////////////////////////////////////////
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            n_fail++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic apb(input logic is_wr, input logic [11:0] a,
                       input logic [7:0] d, input logic [33:0] exp);
        logic [31:0] r;
        r = $urandom;
        notes.push_back(exp);
        psel <= 1'b1;
        pwrite <= is_wr;
        paddr <= a;
        pwdata <= {r[31:8], d};
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask

    task automatic wr(input logic [11:0] a, input logic [7:0] d,
                      input logic err);
        apb(1'b1, a, d, {1'b0, err, 32'h0000_0000});
    endtask

    task automatic rd(input logic [11:0] a, input logic [7:0] exp,
                      input logic err);
        apb(1'b0, a, 8'h00, {1'b1, err, 24'h00_0000, exp});
    endtask

    task automatic wait_sig(input logic on_rst);
        int k;
        k = 0;
        while ((on_rst ? system_reset_pulse : timeout_irq_req) !== 1'b1
               && k < 600) begin
            @(posedge pclk);
            k++;
        end
        check(k < 600, 32'h1);
    endtask

    task automatic report_and_stop;
        $display("checks %0d, mismatches %0d", checks_done, n_fail);
        if (n_fail == 0 && checks_done > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

////////////////////////////////////////////////////////////////////////////
    initial begin
        void'($urandom(32'h934f));
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        rd(12'h000, 8'h00, 1'b0);
        rd(12'h004, 8'h00, 1'b0);
        rd(12'h010, 8'h00, 1'b1);
        wr(12'h010, 8'hFF, 1'b1);
        // Interrupt-only mode, global enable off first
        wr(12'h000, 8'h40, 1'b0);
        restart_req <= 1'b0;
        repeat (150) @(posedge pclk);
        check(timeout_irq_req, 32'h0);
        restart_req <= 1'b1;
        rd(12'h000, 8'hC0, 1'b0);
        global_irq_enable <= 1'b1;
        repeat (3) @(posedge pclk);
        check(timeout_irq_req, 32'h1);
        check(n_rst, 32'h0);
        wr(12'h000, 8'hC0, 1'b0);
        rd(12'h000, 8'h40, 1'b0);
        // Combined mode, serviced by the vector
        wr(12'h000, 8'h48, 1'b0);
        restart_req <= 1'b0;
        wait_sig(1'b0);
        check(n_rst, 32'h0);
        irq_vector_enter <= 1'b1;
        restart_req <= 1'b1;
        @(posedge pclk);
        irq_vector_enter <= 1'b0;
        rd(12'h000, 8'h08, 1'b0);
        restart_req <= 1'b0;
        wait_sig(1'b1);
        // Combined mode, left unserviced
        restart_req <= 1'b1;
        wr(12'h000, 8'h48, 1'b0);
        restart_req <= 1'b0;
        wait_sig(1'b0);
        wait_sig(1'b1);
        restart_req <= 1'b1;
        rd(12'h004, 8'h08, 1'b0);
        rd(12'h000, 8'h08, 1'b0);
        wr(12'h000, 8'h00, 1'b0);
        rd(12'h000, 8'h08, 1'b0);
        wr(12'h004, 8'h00, 1'b0);
        rd(12'h004, 8'h00, 1'b0);
        // Change window guards
        wr(12'h000, 8'h0D, 1'b0);
        rd(12'h000, 8'h08, 1'b0);
        wr(12'h000, 8'h18, 1'b0);
        repeat (8) @(posedge pclk);
        wr(12'h000, 8'h00, 1'b0);
        rd(12'h000, 8'h08, 1'b0);
        wr(12'h000, 8'h18, 1'b0);
        wr(12'h000, 8'h21, 1'b0);
        rd(12'h000, 8'h21, 1'b0);
        // Fuse override
        always_on_fuse <= 1'b1;
        repeat (6) @(posedge pclk);
        wr(12'h000, 8'h61, 1'b0);
        rd(12'h000, 8'h29, 1'b0);
        // Reserved period code must act as the longest period
        wr(12'h000, 8'h18, 1'b0);
        wr(12'h000, 8'h2B, 1'b0);
        rd(12'h000, 8'h2B, 1'b0);
        restart_req <= 1'b0;
        repeat (8000) @(posedge pclk);
        check(n_rst, 32'h2);
        wait_sig(1'b1);
        restart_req <= 1'b1;
        @(posedge pclk);
        check(n_rst, 32'h3);
        report_and_stop;
    end
endmodule // watchdog_timer_core_tb
